// file: common/dsw_map.svh
`ifndef DSW_MAP_SVH
`define DSW_MAP_SVH
`define DSW_FRAME_BITS     24
`define DSW_DATA_LSB       0
`define DSW_DATA_MSB       15
`define DSW_MODE_LO_POS    16
`define DSW_MODE_HI_POS    17
`define DSW_MIDSCALE       16'h8000
`define DSW_ZEROSCALE      16'h0000
`define DSW_MODE_RESET     2'h0
`define DSW_CLK_MHZ        100
`define DSW_SCLK_MAX_MHZ   30
`define DSW_SYNC_HIGH_NS   33
`define DSW_SYNC_HIGH_CYC  ((`DSW_SYNC_HIGH_NS * `DSW_CLK_MHZ + 999) / 1000)
`endif

// file: common/dsw_pkg.sv
package dsw_pkg;
    typedef enum logic [1:0] {
        DSW_PM_NORMAL,
        DSW_PM_DOWN_1K,
        DSW_PM_DOWN_100K,
        DSW_PM_DOWN_TRI
    } dsw_power_mode_t;

    typedef struct packed {
        logic [1:0]  power_mode;
        logic [15:0] code;
    } dsw_word_t;

    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic din;
    } dsw_pins_t;
endpackage

// file: core/dsw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dsw_sync #(
    parameter int               WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT  = '0 // Idle level of each pin
) (
    input  wire logic             clk_sys, // System clock
    input  wire logic             reset,   // Async reset, high
    input  wire logic [WIDTH-1:0] raw,     // Pin levels
    output logic      [WIDTH-1:0] level_q, // Agreed level
    output logic      [WIDTH-1:0] rise,    // Agreed rise pulse
    output logic      [WIDTH-1:0] fall     // Agreed fall pulse
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    s1_q[i] <= INIT[i];
                    s2_q[i] <= INIT[i];
                    s3_q[i] <= INIT[i];
                end else begin
                    s1_q[i] <= raw[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                end
            end
            // Level moves once stages two and three agree
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    level_q[i] <= INIT[i];
                end else if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
            assign rise[i] = (s2_q[i] == s3_q[i]) && s3_q[i] && !level_q[i];
            assign fall[i] = (s2_q[i] == s3_q[i]) && !s3_q[i] && level_q[i];
        end
    endgenerate
endmodule // dsw_sync
`default_nettype wire

// file: core/dsw_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsw_map.svh"
module dsw_port #(
    parameter bit ZERO_SCALE_START = 1'b0 // 1: zero-scale, 0: midscale
) (
    input  wire logic        clk_sys,      // System clock
    input  wire logic        reset,        // Async reset, high
    input  wire logic        frame_n,      // Frame select pin, low active
    input  wire logic        sclk,         // Serial clock pin
    input  wire logic        din,          // Serial data pin
    output logic [15:0]      code_q,       // Converter register
    output logic [1:0]       power_mode_q, // Operating mode
    output logic             update_q,     // Word executed pulse
    output logic             abort_q       // Frame aborted pulse
);
    // =====================================================
    // Pin sampling
    // =====================================================
    dsw_pkg::dsw_pins_t pins;
    dsw_pkg::dsw_pins_t lvl;
    dsw_pkg::dsw_pins_t fall;
    // Frame select inverted so that one means frame open
    assign pins = {!frame_n, sclk, din};

    // Idle levels: frame closed, serial clock high, data low
    dsw_sync #(.WIDTH(3), .INIT(3'h2)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .raw     (pins),
        .level_q (lvl),
        .rise    (),
        .fall    (fall)
    );

    logic frame_on;
    logic frame_end;
    logic sclk_fall;
    logic bit_in;
    assign frame_on  = lvl.frame_n;
    assign frame_end = fall.frame_n;
    assign sclk_fall = fall.sclk;
    assign bit_in    = lvl.din;

    // =====================================================
    // Frame state
    // =====================================================
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_DONE
    } dsw_state_t;

    dsw_state_t       state_q;
    logic [23:0]      shift_q;
    logic [4:0]       count_q;
    logic             last_bit;
    dsw_pkg::dsw_word_t word;
    assign last_bit = sclk_fall && frame_on &&
                      (count_q == 5'(`DSW_FRAME_BITS - 1));
    assign word = {shift_q[16:0], bit_in};

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (frame_on && !frame_end) begin
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (frame_end) begin
                        state_q <= ST_IDLE;
                    end else if (last_bit) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // New frame needs frame select high first
                    if (!frame_on) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Shift register and bit count
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            shift_q <= 24'h000000;
            count_q <= 5'h00;
        end else if (state_q != ST_SHIFT || frame_end) begin
            shift_q <= 24'h000000;
            count_q <= 5'h00;
        end else if (last_bit) begin
            // Last bit closes the count; word is executed alongside
            shift_q <= {shift_q[22:0], bit_in};
            count_q <= 5'h00;
        end else if (sclk_fall) begin
            shift_q <= {shift_q[22:0], bit_in};
            count_q <= count_q + 5'h01;
        end
    end

    // =====================================================
    // Execute
    // =====================================================
    localparam logic [15:0] PRELOAD = ZERO_SCALE_START ? `DSW_ZEROSCALE
                                                       : `DSW_MIDSCALE;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            code_q       <= PRELOAD;
            power_mode_q <= `DSW_MODE_RESET;
        end else if (state_q == ST_SHIFT && !frame_end && last_bit) begin
            code_q       <= word.code;
            power_mode_q <= word.power_mode;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            update_q <= 1'b0;
            abort_q  <= 1'b0;
        end else begin
            update_q <= (state_q == ST_SHIFT) && !frame_end && last_bit;
            abort_q  <= (state_q == ST_SHIFT) && frame_end;
        end
    end

    // =====================================================
    // Checks
    // =====================================================
    sequence s_frame_full;
        (state_q == ST_SHIFT) && !frame_end && last_bit;
    endsequence

    a_update_pulse: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_frame_full |=> update_q && code_q == $past(word.code))
        else $error("Word not executed on last bit");

    a_mode_update: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_frame_full |=> power_mode_q == $past(word.power_mode))
        else $error("Mode bits not taken");

    a_abort_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_q == ST_SHIFT && frame_end) |=>
            abort_q && $stable(code_q) && $stable(power_mode_q)
            && count_q == 5'h00)
        else $error("Abort changed outputs");

    a_code_stable: assert property (
        @(posedge clk_sys) disable iff (reset)
        !update_q |-> $stable(code_q))
        else $error("Code changed without update");

    a_no_shift_idle: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_q != ST_SHIFT) |=> count_q == 5'h00)
        else $error("Shift outside frame");

    a_count_bound: assert property (
        @(posedge clk_sys) disable iff (reset)
        count_q < 5'(`DSW_FRAME_BITS))
        else $error("Bit count past frame");

    a_shift_fall: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_q == ST_SHIFT && !frame_end && !sclk_fall) |=>
            $stable(count_q))
        else $error("Shift without clock fall");

    a_exclusive: assert property (
        @(posedge clk_sys) disable iff (reset)
        !(update_q && abort_q))
        else $error("Update and abort together");

    // Frame opening and single bit steps
    sequence s_frame_open;
        (state_q == ST_IDLE) && frame_on && !frame_end;
    endsequence

    sequence s_bit_taken;
        (state_q == ST_SHIFT) && !frame_end && sclk_fall && !last_bit;
    endsequence

    a_frame_open: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_frame_open |=> state_q == ST_SHIFT && count_q == 5'h00)
        else $error("Frame not opened");

    a_bit_capture: assert property (
        @(posedge clk_sys) disable iff (reset)
        s_bit_taken |=> count_q == $past(count_q) + 5'h01
            && shift_q[0] == $past(bit_in))
        else $error("Bit not captured on clock fall");

    a_idle_no_pulse: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_q != ST_SHIFT) |=> !update_q && !abort_q)
        else $error("Pulse outside open frame");

    a_done_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        (state_q == ST_DONE && frame_on) |=> state_q == ST_DONE)
        else $error("Left done with frame still open");

    a_reset_preload: assert property (
        @(posedge clk_sys)
        $fell(reset) |-> code_q == PRELOAD
            && power_mode_q == `DSW_MODE_RESET)
        else $error("Reset preload missing");
endmodule // dsw_port
`default_nettype wire

// file: testbench/dsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsw_host_model (
    output logic frame_n, // Frame select, low active
    output logic sclk,    // Serial clock, idles high
    output logic din      // Serial data
);
    initial begin
        frame_n = 1'b1;
        sclk    = 1'b1;
        din     = 1'b0;
    end
    // Shift n bits MSB first; fewer than 24 ends as an abort
    task automatic send(input logic [23:0] w, input int n);
        #1; // Keeps pin moves off the system clock edges
        frame_n = 1'b0;
        #62.5;
        for (int i = 23; i > 23 - n; i--) begin
            din = w[i];
            #62.5;
            sclk = 1'b0;
            #62.5;
            sclk = 1'b1;
        end
        #62.5;
        frame_n = 1'b1;
        din     = ~din;
        #250;
    endtask
    // Clock pulses while the frame is closed
    task automatic stray(input int n);
        #1;
        for (int i = 0; i < n; i++) begin
            din = ~din;
            #62.5;
            sclk = 1'b0;
            #62.5;
            sclk = 1'b1;
        end
        #250;
    endtask
endmodule // dsw_host_model
`default_nettype wire

// file: testbench/tb_dac_serial_write_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dac_serial_write_port;
    logic        clk_sys, reset, frame_n, sclk, din, update_q, abort_q;
    logic [15:0] code_q, exp_code;
    logic [1:0]  power_mode_q, exp_mode;
    int          n_mismatch = 0, samples_checked = 0, seed = 28818;
    int          cycles = 0, n_upd = 0, n_abt = 0, n_before = 0;

    dsw_port u_dut (.clk_sys(clk_sys), .reset(reset), .frame_n(frame_n),
        .sclk(sclk), .din(din), .code_q(code_q),
        .power_mode_q(power_mode_q), .update_q(update_q),
        .abort_q(abort_q));
    dsw_host_model u_host (.frame_n(frame_n), .sclk(sclk), .din(din));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        cycles++;
        if (update_q === 1'b1) n_upd++;
        if (abort_q === 1'b1) n_abt++;
        if (cycles >= 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    function automatic logic [17:0] expect_of(input logic [23:0] w);
        return w[17:0];
    endfunction
    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One frame of n bits, then outputs and pulse counts compared
    task automatic frame(input logic [23:0] w, input int n);
        int u0, a0;
        u0 = n_upd;
        a0 = n_abt;
        u_host.send(w, n);
        repeat (10) @(negedge clk_sys);
        if (n >= 24) {exp_mode, exp_code} = expect_of(w);
        chk("code", {8'h00, exp_code}, {8'h00, code_q});
        chk("mode", {22'h0, exp_mode}, {22'h0, power_mode_q});
        chk("updates", (n >= 24) ? 24'h1 : 24'h0, 24'(n_upd - u0));
        chk("aborts", (n >= 24) ? 24'h0 : 24'h1, 24'(n_abt - a0));
    endtask
    task automatic reset_check();
        reset = 1'b1;
        repeat (20) @(negedge clk_sys);
        reset = 1'b0;
        repeat (5) @(negedge clk_sys);
        exp_code = 16'h8000;
        exp_mode = 2'h0;
        chk("reset code", 24'h008000, {8'h00, code_q});
        chk("reset mode", 24'h000000, {22'h0, power_mode_q});
        $display("test reset done");
    endtask

    initial begin
        reset = 1'b1;
        reset_check();
        for (int m = 0; m < 4; m++) begin
            frame(24'($random(seed)) & 24'hFCFFFF | 24'(m << 16), 24);
        end
        frame(24'hFFFFFF, 24);
        frame(24'h000000, 24);
        for (int i = 0; i < 4; i++) frame(24'($random(seed)), 24);
        $display("test frames done");
        frame(24'h02ABCD, 23);
        frame(24'h01FFFF, 1);
        frame(24'h031234, 24);
        $display("test abort done");
        n_before = n_upd + n_abt;
        u_host.stray(30);
        repeat (10) @(negedge clk_sys);
        chk("stray code", {8'h00, exp_code}, {8'h00, code_q});
        chk("stray mode", {22'h0, exp_mode}, {22'h0, power_mode_q});
        chk("stray pulses", 24'h0, 24'(n_upd + n_abt - n_before));
        $display("test closed frame done");
        reset_check();
        frame(24'($random(seed)), 24);
        $display("test restart done");
        close_out();
    end
endmodule // tb_dac_serial_write_port
`default_nettype wire
